/* src/sae_pkg.sv */
package sae_pkg;
  localparam int VA_W = 16;
  localparam int PA_W = 22;
  localparam int PG_W = 8;
  localparam int OFS_W = 14;
  localparam int SEG_W = 6;
  localparam int RA_W = 8;
  localparam int PP_W = 6;
  localparam int NEST_W = 4;
  localparam logic [PP_W-1:0] EXT_PAGE = 6'h15;
  localparam logic [RA_W-1:0] R_DPS0 = 8'hf0;
  localparam logic [RA_W-1:0] R_DPS1 = 8'hf1;
  localparam logic [RA_W-1:0] R_DPS2 = 8'hf2;
  localparam logic [RA_W-1:0] R_DPS3 = 8'hf3;
  localparam logic [RA_W-1:0] R_CSEG = 8'hf4;
  localparam logic [RA_W-1:0] R_ISEG = 8'hf8;
  localparam logic [RA_W-1:0] R_TSEG = 8'hf9;
  localparam logic [RA_W-1:0] R_DPS_RELOC0 = 8'he0;
  localparam logic [SEG_W-1:0] CSEG_RST = 6'h00;
  localparam logic [NEST_W-1:0] NEST_RST = 4'h0;

  typedef enum logic [1:0] {ACC_DATA, ACC_FETCH, ACC_VECTOR, ACC_DMA} sae_acc_t;
  typedef enum logic [2:0] {SEL_NONE, SEL_DPS, SEL_CSEG, SEL_ISEG, SEL_TSEG, SEL_PORT} sae_sel_t;

  function automatic sae_sel_t sae_decode(input logic [RA_W-1:0] a,
                                          input logic [PP_W-1:0] pg,
                                          input logic reloc);
    sae_sel_t s;
    s = SEL_NONE;
    if (reloc && a[7:2] == R_DPS_RELOC0[7:2])
      s = SEL_DPS;
    else if (pg == EXT_PAGE)
    begin
      if (a[7:2] == R_DPS0[7:2])
        s = reloc ? SEL_PORT : SEL_DPS;
      else if (a == R_CSEG)
        s = SEL_CSEG;
      else if (a == R_ISEG)
        s = SEL_ISEG;
      else if (a == R_TSEG)
        s = SEL_TSEG;
    end
    return s;
  endfunction
endpackage

/* src/sae_page_map.sv */
`timescale 1ns/1ps
module sae_page_map
  import sae_pkg::*;
(
  input wire logic clk_i,
  input wire logic wr_i,
  input wire logic [1:0] wr_idx_i,
  input wire logic [PG_W-1:0] wdata_i,
  input wire logic [1:0] rd_idx_i,
  output logic [PG_W-1:0] rdata_o,
  input wire logic [VA_W-1:0] vaddr_i,
  output logic [PA_W-1:0] paged_addr_o
);
  logic [PG_W-1:0] dps_q [4];
  logic [PG_W-1:0] dps_d [4];

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      dps_d[i] = dps_q[i];
      if (wr_i && wr_idx_i == i[1:0])
        dps_d[i] = wdata_i;
    end
  end

  // no reset: selectors power up undefined
  always_ff @(posedge clk_i)
  begin
    dps_q <= dps_d;
  end

  assign rdata_o = dps_q[rd_idx_i];
  // top two bits index the selector, offset passes straight
  assign paged_addr_o = {dps_q[vaddr_i[15:14]], vaddr_i[OFS_W-1:0]};
endmodule

/* src/sae_seg_regs.sv */
`timescale 1ns/1ps
module sae_seg_regs
  import sae_pkg::*;
(
  input wire logic clk_i,
  input wire logic iseg_wr_i,
  input wire logic tseg_wr_i,
  input wire logic [SEG_W-1:0] wdata_i,
  output logic [SEG_W-1:0] iseg_o,
  output logic [SEG_W-1:0] tseg_o
);
  logic [SEG_W-1:0] iseg_q;
  logic [SEG_W-1:0] iseg_d;
  logic [SEG_W-1:0] tseg_q;
  logic [SEG_W-1:0] tseg_d;

  always_comb
  begin
    iseg_d = iseg_wr_i ? wdata_i : iseg_q;
    tseg_d = tseg_wr_i ? wdata_i : tseg_q;
  end

  // no reset on purpose: software must load both before use
  always_ff @(posedge clk_i)
  begin
    iseg_q <= iseg_d;
    tseg_q <= tseg_d;
  end

  assign iseg_o = iseg_q;
  assign tseg_o = tseg_q;
endmodule

/* src/sae_top.sv */
`timescale 1ns/1ps
module sae_top
  import sae_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic acc_valid_i,
  input wire sae_acc_t acc_kind_i,
  input wire logic [VA_W-1:0] vaddr_i,
  input wire logic prog_space_data_i,
  input wire logic transfer_segment_choice_i,
  input wire logic segment_save_mode_i,
  input wire logic page_selector_relocate_i,
  input wire logic int_entry_i,
  input wire logic int_return_i,
  input wire logic cseg_load_i,
  input wire logic [SEG_W-1:0] cseg_load_val_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [RA_W-1:0] reg_addr_i,
  input wire logic [PP_W-1:0] reg_page_i,
  input wire logic [7:0] reg_wdata_i,
  output logic phys_valid_o,
  output logic [PA_W-1:0] phys_addr_o,
  output logic phys_paged_o,
  output logic [7:0] reg_rdata_o,
  output logic reg_hit_o,
  output logic port_data_redirect_o,
  output logic [SEG_W-1:0] cseg_stack_o,
  output logic in_service_o
);
  sae_sel_t sel;
  logic [PG_W-1:0] dps_rdata;
  logic [PA_W-1:0] page_addr;
  logic [SEG_W-1:0] iseg_val;
  logic [SEG_W-1:0] tseg_val;
  logic dps_wr;
  logic iseg_wr;
  logic tseg_wr;
  logic [1:0] dps_idx;

  logic [SEG_W-1:0] cseg_q;
  logic [SEG_W-1:0] cseg_d;
  logic [SEG_W-1:0] stack_q;
  logic [SEG_W-1:0] stack_d;
  logic [NEST_W-1:0] nest_q;
  logic [NEST_W-1:0] nest_d;
  logic svc_q;
  logic svc_d;

  logic use_page;
  logic [SEG_W-1:0] code_seg;
  logic [SEG_W-1:0] seg_val;
  logic [PA_W-1:0] phys_d;
  logic [PA_W-1:0] phys_q;
  logic pvalid_q;
  logic paged_d;
  logic paged_q;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic hit_d;
  logic hit_q;
  logic redir_d;
  logic redir_q;

  // register file decode
  always_comb
  begin
    sel = sae_decode(reg_addr_i, reg_page_i, page_selector_relocate_i);
    dps_idx = reg_addr_i[1:0];
    dps_wr = reg_wr_i && sel == SEL_DPS;
    iseg_wr = reg_wr_i && sel == SEL_ISEG;
    tseg_wr = reg_wr_i && sel == SEL_TSEG;
  end

  sae_page_map u_page_map (
    .clk_i(clk_i),
    .wr_i(dps_wr),
    .wr_idx_i(dps_idx),
    .wdata_i(reg_wdata_i),
    .rd_idx_i(dps_idx),
    .rdata_o(dps_rdata),
    .vaddr_i(vaddr_i),
    .paged_addr_o(page_addr)
  );

  // upper two written bits dropped; software keeps them zero anyway
  sae_seg_regs u_seg_regs (
    .clk_i(clk_i),
    .iseg_wr_i(iseg_wr),
    .tseg_wr_i(tseg_wr),
    .wdata_i(reg_wdata_i[SEG_W-1:0]),
    .iseg_o(iseg_val),
    .tseg_o(tseg_val)
  );

  // code segment and interrupt nesting
  always_comb
  begin
    cseg_d = cseg_q;
    stack_d = stack_q;
    nest_d = nest_q;
    if (int_entry_i)
    begin
      if (segment_save_mode_i)
      begin
        stack_d = cseg_q;
        cseg_d = iseg_val;
      end
      else if (nest_q != {NEST_W{1'b1}})
        nest_d = nest_q + 4'h1;
    end
    else if (cseg_load_i)
      cseg_d = cseg_load_val_i;
    else if (reg_wr_i && sel == SEL_CSEG)
      cseg_d = reg_wdata_i[SEG_W-1:0];
    // save-mode return restores through cseg_load_i from the stacked value
    if (int_return_i && !int_entry_i && !segment_save_mode_i && nest_q != NEST_RST)
      nest_d = nest_q - 4'h1;
    svc_d = nest_d != NEST_RST;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cseg_q <= CSEG_RST;
      stack_q <= CSEG_RST;
      nest_q <= NEST_RST;
      svc_q <= 1'b0;
    end
    else
    begin
      cseg_q <= cseg_d;
      stack_q <= stack_d;
      nest_q <= nest_d;
      svc_q <= svc_d;
    end
  end

  // translation select, from this cycle's access and the nesting count (nest_q)
  always_comb
  begin
    code_seg = (nest_q != NEST_RST) ? iseg_val : cseg_q;
    use_page = 1'b0;
    unique case (acc_kind_i)
      ACC_DATA:
      begin
        use_page = !prog_space_data_i;
        seg_val = code_seg;
      end
      ACC_FETCH: seg_val = code_seg;
      ACC_VECTOR: seg_val = iseg_val;
      ACC_DMA: seg_val = transfer_segment_choice_i ? tseg_val : iseg_val;
    endcase
    // address holds between accesses so the bus sees no glitching
    phys_d = phys_q;
    paged_d = paged_q;
    if (acc_valid_i)
    begin
      phys_d = use_page ? page_addr : {seg_val, vaddr_i};
      paged_d = use_page;
    end
  end

  // register readback; reserved bits read zero
  always_comb
  begin
    rdata_d = 8'h00;
    hit_d = 1'b0;
    redir_d = 1'b0;
    if (reg_rd_i || reg_wr_i)
    begin
      unique case (sel)
        SEL_NONE: hit_d = 1'b0;
        SEL_DPS: hit_d = 1'b1;
        SEL_CSEG: hit_d = 1'b1;
        SEL_ISEG: hit_d = 1'b1;
        SEL_TSEG: hit_d = 1'b1;
        SEL_PORT: redir_d = 1'b1;
        default: hit_d = 1'b0;
      endcase
    end
    if (reg_rd_i)
    begin
      unique case (sel)
        SEL_DPS: rdata_d = dps_rdata;
        SEL_CSEG: rdata_d = {2'b00, cseg_q};
        SEL_ISEG: rdata_d = {2'b00, iseg_val};
        SEL_TSEG: rdata_d = {2'b00, tseg_val};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      phys_q <= {PA_W{1'b0}};
      pvalid_q <= 1'b0;
      paged_q <= 1'b0;
      rdata_q <= 8'h00;
      hit_q <= 1'b0;
      redir_q <= 1'b0;
    end
    else
    begin
      phys_q <= phys_d;
      pvalid_q <= acc_valid_i;
      paged_q <= paged_d;
      rdata_q <= rdata_d;
      hit_q <= hit_d;
      redir_q <= redir_d;
    end
  end

  assign phys_valid_o = pvalid_q;
  assign phys_addr_o = phys_q;
  assign phys_paged_o = paged_q;
  assign reg_rdata_o = rdata_q;
  assign reg_hit_o = hit_q;
  assign port_data_redirect_o = redir_q;
  assign cseg_stack_o = stack_q;
  assign in_service_o = svc_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_valid_follow: assert property (
    phys_valid_o == $past(acc_valid_i))
    else $error("valid does not follow access");

  a_page_offset: assert property (
    acc_valid_i && acc_kind_i == ACC_DATA && !prog_space_data_i
    |=> phys_addr_o[13:0] == $past(vaddr_i[13:0]) && phys_paged_o)
    else $error("page offset altered");

  a_page_number: assert property (
    acc_valid_i && acc_kind_i == ACC_DATA && !prog_space_data_i
    |=> phys_addr_o[21:14] == $past(u_page_map.dps_q[vaddr_i[15:14]]))
    else $error("wrong page number");

  a_seg_fetch: assert property (
    acc_valid_i && acc_kind_i == ACC_FETCH && nest_q == NEST_RST
    |=> phys_addr_o == {$past(cseg_q), $past(vaddr_i)} && !phys_paged_o)
    else $error("fetch not extended by code segment");

  a_spm_data: assert property (
    acc_valid_i && acc_kind_i == ACC_DATA && prog_space_data_i && nest_q == NEST_RST
    |=> phys_addr_o[21:16] == $past(cseg_q))
    else $error("program-space data not on code segment");

  a_vector_isr: assert property (
    acc_valid_i && acc_kind_i == ACC_VECTOR
    |=> phys_addr_o[21:16] == $past(iseg_val))
    else $error("vector fetch not on interrupt segment");

  a_dma_choice: assert property (
    acc_valid_i && acc_kind_i == ACC_DMA
    |=> phys_addr_o[21:16] == ($past(transfer_segment_choice_i) ?
                               $past(tseg_val) : $past(iseg_val)))
    else $error("dma segment choice wrong");

  a_seg_not_paged: assert property (
    acc_valid_i && acc_kind_i != ACC_DATA |=> !phys_paged_o)
    else $error("segment access went through page selectors");

  a_compat_fetch: assert property (
    acc_valid_i && acc_kind_i == ACC_FETCH && nest_q != NEST_RST
    |=> phys_addr_o[21:16] == $past(iseg_val))
    else $error("service fetch not on interrupt segment");

  a_iseg_write: assert property (
    reg_wr_i && sel == SEL_ISEG |=> iseg_val == $past(reg_wdata_i[SEG_W-1:0]))
    else $error("interrupt segment write lost");

  a_cseg_far_load: assert property (
    cseg_load_i && !int_entry_i |=> cseg_q == $past(cseg_load_val_i))
    else $error("far transfer did not load code segment");

  a_entry_save: assert property (
    int_entry_i && segment_save_mode_i
    |=> cseg_q == $past(iseg_val) && cseg_stack_o == $past(cseg_q))
    else $error("save-mode entry wrong");

  a_entry_compat: assert property (
    int_entry_i && !segment_save_mode_i && !int_return_i |=> in_service_o)
    else $error("compat entry not in service");

  a_seg_reserved: assert property (
    reg_rd_i && (sel == SEL_CSEG || sel == SEL_ISEG || sel == SEL_TSEG)
    |=> reg_rdata_o[7:6] == 2'b00 && reg_hit_o)
    else $error("reserved segment bits not zero");

  a_reloc_map: assert property (
    reg_rd_i && page_selector_relocate_i && reg_addr_i[7:2] == R_DPS_RELOC0[7:2]
    |=> reg_hit_o ##0 reg_rdata_o == $past(dps_rdata))
    else $error("relocated selector not mapped");

  a_page_only21: assert property (
    reg_rd_i && reg_page_i != EXT_PAGE && reg_addr_i[7:4] == 4'hf
    |=> !reg_hit_o && reg_rdata_o == 8'h00)
    else $error("hit outside page 21");

  c_data_page: cover property (
    acc_valid_i && acc_kind_i == ACC_DATA && vaddr_i[15:14] == 2'h3);
  c_dma_xfer_seg: cover property (
    acc_valid_i && acc_kind_i == ACC_DMA && transfer_segment_choice_i);
  c_compat_isr_fetch: cover property (
    in_service_o && acc_valid_i && acc_kind_i == ACC_FETCH);
  c_port_redirect: cover property (port_data_redirect_o);
endmodule

/* tb/sae_core_model.sv */
`timescale 1ns/1ps
module sae_core_model
  import sae_pkg::*;
(
  input wire logic clk_i,
  output logic acc_valid_o,
  output sae_acc_t acc_kind_o,
  output logic [VA_W-1:0] vaddr_o,
  output logic prog_space_data_o
);
  // accesses never target the register file, so no selector is rewritten
  // through its own translation
  initial
  begin
    acc_valid_o = 1'b0;
    acc_kind_o = ACC_DATA;
    vaddr_o = 16'h0000;
    prog_space_data_o = 1'b0;
  end

  task automatic access(input sae_acc_t kind, input logic [VA_W-1:0] va, input logic prog);
    @(posedge clk_i);
    #1;
    acc_valid_o = 1'b1;
    acc_kind_o = kind;
    vaddr_o = va;
    prog_space_data_o = prog;
    @(posedge clk_i);
    #1;
    acc_valid_o = 1'b0;
    // released bus must not keep showing the old address
    vaddr_o = ~va;
  endtask
endmodule

/* tb/segmented_address_extender_bench.sv */
`timescale 1ns/1ps
module segmented_address_extender_bench
  import sae_pkg::*;
;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic acc_valid;
  sae_acc_t acc_kind;
  logic [VA_W-1:0] vaddr;
  logic psd;
  logic tsc = 1'b0;
  logic ssm = 1'b0;
  logic rel = 1'b0;
  logic ient = 1'b0;
  logic iret = 1'b0;
  logic cld = 1'b0;
  logic [SEG_W-1:0] cval = 6'h00;
  logic rwr = 1'b0;
  logic rrd = 1'b0;
  logic [7:0] radr = 8'h00;
  logic [5:0] rpg = 6'h00;
  logic [7:0] rwd = 8'h00;
  logic pv, pp, hit, redir, insv;
  logic [PA_W-1:0] pa;
  logic [7:0] rdat;
  logic [SEG_W-1:0] cstk;
  logic [7:0] dp [4];
  int error_cnt = 0;
  int comparisons = 0;

  sae_core_model m (.clk_i(clk_i), .acc_valid_o(acc_valid), .acc_kind_o(acc_kind),
    .vaddr_o(vaddr), .prog_space_data_o(psd));

  sae_top DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .acc_valid_i(acc_valid),
    .acc_kind_i(acc_kind), .vaddr_i(vaddr), .prog_space_data_i(psd),
    .transfer_segment_choice_i(tsc), .segment_save_mode_i(ssm),
    .page_selector_relocate_i(rel), .int_entry_i(ient), .int_return_i(iret),
    .cseg_load_i(cld), .cseg_load_val_i(cval), .reg_wr_i(rwr), .reg_rd_i(rrd),
    .reg_addr_i(radr), .reg_page_i(rpg), .reg_wdata_i(rwd), .phys_valid_o(pv),
    .phys_addr_o(pa), .phys_paged_o(pp), .reg_rdata_o(rdat), .reg_hit_o(hit),
    .port_data_redirect_o(redir), .cseg_stack_o(cstk), .in_service_o(insv));

  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic stop_test();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // software keeps bits 7:6 of segment writes at zero
  task automatic rop(input logic w, input logic [7:0] a, input logic [5:0] pg,
                     input logic [7:0] d);
    @(posedge clk_i);
    #1;
    rwr = w;
    rrd = !w;
    radr = a;
    rpg = pg;
    rwd = d;
    @(posedge clk_i);
    #1;
    rwr = 1'b0;
    rrd = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [5:0] pg, input logic [7:0] e);
    rop(1'b0, a, pg, 8'h00);
    chk(rdat, e);
  endtask

  task automatic acc(input sae_acc_t k, input logic [15:0] va, input logic p,
                     input logic [21:0] e, input logic pg);
    m.access(k, va, p);
    chk(pv, 1'b1);
    chk(pa, e);
    chk(pp, pg);
  endtask

  task automatic pulse(input logic e, input logic r, input logic l);
    @(posedge clk_i);
    #1;
    ient = e;
    iret = r;
    cld = l;
    @(posedge clk_i);
    #1;
    ient = 1'b0;
    iret = 1'b0;
    cld = 1'b0;
  endtask

  initial
  begin
    #100000;
    error_cnt++;
    stop_test();
  end

  initial
  begin
    repeat (10) @(posedge clk_i);
    #1;
    arst_n_i = 1'b1;
    rd(R_CSEG, EXT_PAGE, 8'h00);
    chk(hit, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      dp[i] = 8'ha0 + 8'h15 * i[7:0];
      rop(1'b1, R_DPS0 + i[7:0], EXT_PAGE, dp[i]);
      rd(R_DPS0 + i[7:0], EXT_PAGE, dp[i]);
    end
    for (int i = 0; i < 4; i++)
    begin
      acc(ACC_DATA, {i[1:0], 14'h0000}, 1'b0, {dp[i], 14'h0000}, 1'b1);
      acc(ACC_DATA, {i[1:0], 14'h3fff}, 1'b0, {dp[i], 14'h3fff}, 1'b1);
    end
    rop(1'b1, R_CSEG, EXT_PAGE, 8'h2a);
    rd(R_CSEG, EXT_PAGE, 8'h2a);
    acc(ACC_FETCH, 16'h1234, 1'b0, {6'h2a, 16'h1234}, 1'b0);
    acc(ACC_DATA, 16'hc001, 1'b1, {6'h2a, 16'hc001}, 1'b0);
    rop(1'b1, R_ISEG, EXT_PAGE, 8'h13);
    rop(1'b1, R_TSEG, EXT_PAGE, 8'h3c);
    rd(R_ISEG, EXT_PAGE, 8'h13);
    rd(R_TSEG, EXT_PAGE, 8'h3c);
    tsc = 1'b1;
    acc(ACC_DMA, 16'h8765, 1'b0, {6'h3c, 16'h8765}, 1'b0);
    tsc = 1'b0;
    acc(ACC_DMA, 16'h4321, 1'b0, {6'h13, 16'h4321}, 1'b0);
    acc(ACC_VECTOR, 16'h0010, 1'b0, {6'h13, 16'h0010}, 1'b0);
    cval = 6'h05;
    pulse(1'b0, 1'b0, 1'b1);
    rd(R_CSEG, EXT_PAGE, 8'h05);
    pulse(1'b1, 1'b0, 1'b0);
    chk(insv, 1'b1);
    acc(ACC_FETCH, 16'h0200, 1'b0, {6'h13, 16'h0200}, 1'b0);
    pulse(1'b0, 1'b1, 1'b0);
    chk(insv, 1'b0);
    acc(ACC_FETCH, 16'h0200, 1'b0, {6'h05, 16'h0200}, 1'b0);
    ssm = 1'b1;
    pulse(1'b1, 1'b0, 1'b0);
    chk(cstk, 6'h05);
    acc(ACC_FETCH, 16'h0300, 1'b0, {6'h13, 16'h0300}, 1'b0);
    rel = 1'b1;
    rop(1'b1, R_DPS_RELOC0 + 8'h02, 6'h00, 8'h77);
    rd(R_DPS_RELOC0 + 8'h02, 6'h00, 8'h77);
    acc(ACC_DATA, 16'h8000, 1'b0, {8'h77, 14'h0000}, 1'b1);
    rop(1'b0, R_DPS1, EXT_PAGE, 8'h00);
    chk(redir, 1'b1);
    rd(8'hf5, EXT_PAGE, 8'h00);
    chk(hit, 1'b0);
    // mid-run reset: code segment was moved off zero above
    @(posedge clk_i);
    #1;
    arst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk(cstk, 6'h00);
    arst_n_i = 1'b1;
    rd(R_CSEG, EXT_PAGE, 8'h00);
    stop_test();
  end
endmodule
